// File: clk_buf_cfg_map.svh
// Offsets, field positions and reset values of the clock and buffer registers
`ifndef CLK_BUF_CFG_MAP_SVH
`define CLK_BUF_CFG_MAP_SVH
`define CLK_STRAP_CONFIG_OFS 12'h048
`define UPSTREAM_BUF_THRESH_OFS 12'h04C
`define CLK_STRAP_CONFIG_RST 32'h00000100
`define UPSTREAM_BUF_THRESH_RST 32'h00000307
`define CS_SPEED_LSB 0
`define CS_SOURCE_BIT 3
`define CS_GATE_EN_BIT 4
`define CS_COMPAT_BIT 7
`define CS_PLL_BIT 8
`define UB_THRESH_LSB 0
`define UB_ALLOC_LSB 8
`define CLK_STRAP_WMASK 32'h0000019F
`define UPSTREAM_BUF_WMASK 32'h0000031F
`define THRESH_STEP_BYTES 11'h010
`define ALLOC_256_BYTES 11'h100
`define ALLOC_512_BYTES 11'h200
`define ALLOC_1024_BYTES 11'h400
`endif

// File: clk_buf_cfg_pkg.sv
// Types shared by the clock and buffer configuration block
package clk_buf_cfg_pkg;
  typedef enum logic [1:0] {
    speed_25,
    speed_33,
    speed_50,
    speed_66
  } bus_speed_t;
endpackage

// File: bridge_clock_and_buffer_config.sv
// Clock strap and upstream buffer threshold configuration registers
//
// Functional notes
// RQ1 - PLL select 1 gives 400 MHz with 50/50 clock, 0 gives 200 MHz 33/66.
// RQ2 - Software should leave PLL select at its reset value of one.
// RQ3 - Compatibility bit 7 set enters legacy mode; resets to zero.
// RQ4 - Gate enable stops four secondary clocks only in D3hot at 33 MHz.
// RQ5 - Gating enabled updates power management bus-clock and B2/B3 bits.
// RQ6 - Gate enable is ignored when the secondary bus exceeds 33 MHz.
// RQ7 - Source select zero: secondary clock 33 or 66 MHz from the strap pin.
// RQ8 - Source select one: secondary clock speed from the speed field.
// RQ9 - Speed bits: 00=25, 01=33, 10=50, 11=66 MHz; top bit ignored.
// RQ10 - Completion space per read is min of request length and limit.
// RQ11 - Allocation field: 11=1024, 10=512, 01 and 00=256 bytes.
// RQ12 - Posted data forwards once buffered length reaches the threshold.
// RQ13 - Threshold codes step 16 bytes: code zero 16, reset code seven 128.
// RQ14 - Other buffer events may also trigger forwarding before the threshold.
// RQ15 - Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "clk_buf_cfg_map.svh"

module bridge_clock_and_buffer_config #(
  parameter int ADDR_W = 12,
  parameter int LEN_W = 11
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Configuration space access
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [ADDR_W-1:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  // Strap and power state
  input wire logic m66_enable_strap_in,
  input wire logic d3hot_in,
  // Clock controls
  output logic pll_400_out,
  output logic legacy_mode_out,
  output logic [1:0] secondary_speed_out,
  output logic [3:0] secondary_clock_gate_out,
  output logic bus_power_clock_ctrl_en_out,
  output logic b2_b3_support_out,
  // Upstream buffers
  input wire logic [LEN_W-1:0] read_req_len_in,
  output logic [LEN_W-1:0] completion_alloc_out,
  input wire logic [LEN_W-1:0] posted_fill_in,
  input wire logic posted_other_event_in,
  output logic posted_forward_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] clock_strap_config;
  logic [31:0] upstream_buffer_thresholds;
  logic m66_meta;
  logic m66_sync;
  logic d3_meta;
  logic d3_sync;
  logic [31:0] byte_mask;
  clk_buf_cfg_pkg::bus_speed_t speed;
  logic slow_bus;
  logic [LEN_W-1:0] alloc_limit;
  logic [LEN_W-1:0] threshold_bytes;

  default clocking main_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      byte_mask[8*i +: 8] = {8{cfg_be_in[i]}};
    end
  end

  // Strap and power state come from outside this clock
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      m66_meta <= 1'b0;
      m66_sync <= 1'b0;
      d3_meta <= 1'b0;
      d3_sync <= 1'b0;
    end
    else
    begin
      m66_meta <= m66_enable_strap_in;
      m66_sync <= m66_meta;
      d3_meta <= d3hot_in;
      d3_sync <= d3_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write masks keep reserved bits at zero
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      clock_strap_config <= `CLK_STRAP_CONFIG_RST;
    end
    else if (cfg_wr_in && cfg_addr_in == `CLK_STRAP_CONFIG_OFS)
    begin
      clock_strap_config <= (clock_strap_config & ~byte_mask) |
        (cfg_wdata_in & byte_mask & `CLK_STRAP_WMASK); // RQ15
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      upstream_buffer_thresholds <= `UPSTREAM_BUF_THRESH_RST;
    end
    else if (cfg_wr_in && cfg_addr_in == `UPSTREAM_BUF_THRESH_OFS)
    begin
      upstream_buffer_thresholds <= (upstream_buffer_thresholds & ~byte_mask)
        | (cfg_wdata_in & byte_mask & `UPSTREAM_BUF_WMASK); // RQ15
    end
  end

  // Unmapped offsets read zero
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_rdata_out <= 32'h00000000;
    end
    else if (cfg_rd_in)
    begin
      case (cfg_addr_in)
        `CLK_STRAP_CONFIG_OFS: cfg_rdata_out <= clock_strap_config;
        `UPSTREAM_BUF_THRESH_OFS: cfg_rdata_out <= upstream_buffer_thresholds;
        default: cfg_rdata_out <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock speed selection and gating
  always_comb
  begin
    if (clock_strap_config[`CS_SOURCE_BIT])
    begin
      speed = clk_buf_cfg_pkg::bus_speed_t'(
        clock_strap_config[`CS_SPEED_LSB +: 2]); // RQ8 RQ9
    end
    else if (m66_sync)
    begin
      speed = clk_buf_cfg_pkg::speed_66; // RQ7
    end
    else
    begin
      speed = clk_buf_cfg_pkg::speed_33; // RQ7
    end
  end

  // 25 MHz counts as a 33 MHz-class rate, not faster
  assign slow_bus = speed == clk_buf_cfg_pkg::speed_25 ||
    speed == clk_buf_cfg_pkg::speed_33; // RQ6

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pll_400_out <= 1'b1;
      legacy_mode_out <= 1'b0;
      secondary_speed_out <= 2'h0;
      secondary_clock_gate_out <= 4'h0;
      bus_power_clock_ctrl_en_out <= 1'b0;
      b2_b3_support_out <= 1'b0;
    end
    else
    begin
      pll_400_out <= clock_strap_config[`CS_PLL_BIT]; // RQ1
      legacy_mode_out <= clock_strap_config[`CS_COMPAT_BIT]; // RQ3
      secondary_speed_out <= speed;
      secondary_clock_gate_out <= {4{clock_strap_config[`CS_GATE_EN_BIT]
        && d3_sync && slow_bus}}; // RQ4 RQ6
      bus_power_clock_ctrl_en_out <= clock_strap_config[`CS_GATE_EN_BIT]
        && slow_bus; // RQ5
      b2_b3_support_out <= clock_strap_config[`CS_GATE_EN_BIT]
        && slow_bus; // RQ5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion allocation and posted threshold
  always_comb
  begin
    case (upstream_buffer_thresholds[`UB_ALLOC_LSB +: 2])
      2'h3: alloc_limit = LEN_W'(`ALLOC_1024_BYTES); // RQ11
      2'h2: alloc_limit = LEN_W'(`ALLOC_512_BYTES); // RQ11
      default: alloc_limit = LEN_W'(`ALLOC_256_BYTES); // RQ11
    endcase
  end

  assign threshold_bytes = LEN_W'(
    ({6'h00, upstream_buffer_thresholds[`UB_THRESH_LSB +: 5]} + 11'h001)
    * `THRESH_STEP_BYTES); // RQ13

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      completion_alloc_out <= '0;
      posted_forward_out <= 1'b0;
    end
    else
    begin
      completion_alloc_out <= (read_req_len_in < alloc_limit) ?
        read_req_len_in : alloc_limit; // RQ10
      posted_forward_out <= (posted_fill_in >= threshold_bytes) ||
        posted_other_event_in; // RQ12 RQ14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attempts that start on the release edge would see reset-valued outputs
  gate_needs_slow_a: assert property ( // RQ4
    secondary_clock_gate_out[0] |-> $past(slow_bus) && $past(d3_sync))
    else $error("clock gated outside D3hot slow mode");
  gate_fast_off_a: assert property ( // RQ6
    !slow_bus |=> secondary_clock_gate_out == 4'h0)
    else $error("clock gated at fast rate");
  strap_speed_a: assert property ( // RQ7
    !rst_in && !clock_strap_config[`CS_SOURCE_BIT] |=>
    secondary_speed_out == ($past(m66_sync) ? 2'h3 : 2'h1))
    else $error("strap speed wrong");
  field_speed_a: assert property ( // RQ8 RQ9
    !rst_in && clock_strap_config[`CS_SOURCE_BIT] |=>
    secondary_speed_out == $past(clock_strap_config[1:0]))
    else $error("field speed wrong");
  pll_follow_a: assert property ( // RQ1
    ##1 pll_400_out == $past(clock_strap_config[`CS_PLL_BIT]))
    else $error("pll select not followed");
  legacy_follow_a: assert property ( // RQ3
    cfg_wr_in && cfg_addr_in == `CLK_STRAP_CONFIG_OFS && cfg_be_in[0]
    && cfg_wdata_in[7] |=> ##1 legacy_mode_out)
    else $error("legacy mode not entered");
  alloc_min_a: assert property ( // RQ10 RQ11
    ##1 completion_alloc_out <= $past(alloc_limit)
    && completion_alloc_out <= $past(read_req_len_in))
    else $error("allocation exceeds limit");
  forward_thresh_a: assert property ( // RQ12 RQ13
    !rst_in && posted_fill_in >= threshold_bytes |=> posted_forward_out)
    else $error("threshold reached without forward");
  forward_cause_a: assert property ( // RQ14
    posted_forward_out |-> $past(posted_fill_in >= threshold_bytes)
    || $past(posted_other_event_in))
    else $error("forward without cause");
  reserved_zero_a: assert property ( // RQ15
    (clock_strap_config & ~`CLK_STRAP_WMASK) == 32'h0 &&
    (upstream_buffer_thresholds & ~`UPSTREAM_BUF_WMASK) == 32'h0)
    else $error("reserved bit set");
  gate_cov_c: cover property (secondary_clock_gate_out[0]);
  fwd_cov_c: cover property (posted_forward_out);
  src_cov_c: cover property (
    clock_strap_config[`CS_SOURCE_BIT] && speed == clk_buf_cfg_pkg::speed_50);

endmodule // bridge_clock_and_buffer_config

// File: tb_top.sv
// Self-checking testbench for the clock and buffer configuration registers
`timescale 1ns/1ps
`include "clk_buf_cfg_map.svh"

module tb_top;
  logic sys_clk_in, rst_in, cfg_wr_in, cfg_rd_in;
  logic [11:0] cfg_addr_in;
  logic [3:0] cfg_be_in;
  logic [31:0] cfg_wdata_in, cfg_rdata_out;
  logic m66_enable_strap_in, d3hot_in, posted_other_event_in;
  logic pll_400_out, legacy_mode_out, posted_forward_out;
  logic bus_power_clock_ctrl_en_out, b2_b3_support_out;
  logic [1:0] secondary_speed_out;
  logic [3:0] secondary_clock_gate_out;
  logic [10:0] read_req_len_in, completion_alloc_out, posted_fill_in;
  logic [31:0] m_cs, m_ub, seed;
  int failures, comparisons, cycles, lim, th;

  bridge_clock_and_buffer_config dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
    .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in),
    .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
    .m66_enable_strap_in(m66_enable_strap_in), .d3hot_in(d3hot_in),
    .pll_400_out(pll_400_out), .legacy_mode_out(legacy_mode_out),
    .secondary_speed_out(secondary_speed_out),
    .secondary_clock_gate_out(secondary_clock_gate_out),
    .bus_power_clock_ctrl_en_out(bus_power_clock_ctrl_en_out),
    .b2_b3_support_out(b2_b3_support_out),
    .read_req_len_in(read_req_len_in),
    .completion_alloc_out(completion_alloc_out),
    .posted_fill_in(posted_fill_in),
    .posted_other_event_in(posted_other_event_in),
    .posted_forward_out(posted_forward_out));

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic end_sim;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Model merges enabled byte lanes through the writable mask only
  task automatic wr(input logic [11:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    logic [31:0] bm;
    @(posedge sys_clk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_be_in <= be;
    cfg_wdata_in <= d;
    @(posedge sys_clk_in);
    cfg_wr_in <= 1'b0;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    if (a == `CLK_STRAP_CONFIG_OFS)
      m_cs = (m_cs & ~(bm & `CLK_STRAP_WMASK)) | (d & bm & `CLK_STRAP_WMASK);
    if (a == `UPSTREAM_BUF_THRESH_OFS)
      m_ub = (m_ub & ~(bm & `UPSTREAM_BUF_WMASK))
             | (d & bm & `UPSTREAM_BUF_WMASK);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge sys_clk_in);
    cfg_rd_in <= 1'b0;
    #1 chk(cfg_rdata_out, exp);
  endtask

  task automatic check_all;
    logic [1:0] sp;
    logic gok;
    sp = m_cs[3] ? m_cs[1:0] : (m66_enable_strap_in ? 2'h3 : 2'h1);
    gok = m_cs[4] && sp <= 2'h1;
    chk(32'(pll_400_out), 32'(m_cs[8]));
    chk(32'(legacy_mode_out), 32'(m_cs[7]));
    chk(32'(secondary_speed_out), 32'(sp));
    chk(32'(secondary_clock_gate_out),
        (gok && d3hot_in) ? 32'hF : 32'h0);
    chk(32'({bus_power_clock_ctrl_en_out, b2_b3_support_out}),
        32'({gok, gok}));
    chk(32'(completion_alloc_out), 32'(read_req_len_in) < lim
        ? 32'(read_req_len_in) : lim);
    chk(32'(posted_forward_out), 32'(32'(posted_fill_in) >= th
        || posted_other_event_in));
  endtask

  // Length lands near the current limit when seed[5] is set and fill near the current threshold when seed[19] is set, to hit the boundaries
  task automatic drive_sides;
    lim = m_ub[9:8] == 2'h3 ? 1024 : m_ub[9:8] == 2'h2 ? 512 : 256;
    th = (32'(m_ub[4:0]) + 1) * 16;
    seed = xs(seed);
    m66_enable_strap_in <= seed[0];
    d3hot_in <= seed[1];
    posted_other_event_in <= seed[4:2] == 3'h0;
    read_req_len_in <= seed[5] ? 11'(lim + 32'(seed[7:6]) - 2) : seed[18:8];
    posted_fill_in <= seed[19] ? 11'(th + 32'(seed[21:20]) - 2) : seed[31:21];
    repeat (5) @(posedge sys_clk_in);
    #1 check_all;
  endtask

  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      end_sim;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h00000039;
    {cfg_wr_in, cfg_rd_in, cfg_be_in, cfg_wdata_in, cfg_addr_in} = '0;
    {m66_enable_strap_in, d3hot_in, posted_other_event_in} = 3'h0;
    read_req_len_in = 11'h000;
    posted_fill_in = 11'h000;
    rst_in = 1'b1;
    for (int pass = 0; pass < 2; pass++)
    begin
      m_cs = `CLK_STRAP_CONFIG_RST;
      m_ub = `UPSTREAM_BUF_THRESH_RST;
      repeat (10) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      drive_sides;
      rd(`CLK_STRAP_CONFIG_OFS, m_cs);
      rd(`UPSTREAM_BUF_THRESH_OFS, m_ub);
      for (int i = 0; i < 80; i++)
      begin
        seed = xs(seed);
        // Pass zero keeps the PLL select at one as software should;
        // pass one still moves it so the follow check can trip
        wr(seed[9] ? `UPSTREAM_BUF_THRESH_OFS : seed[8] ? 12'h050
           : `CLK_STRAP_CONFIG_OFS, seed[13:10] | 4'h1,
           xs(seed) | ((pass == 0 && seed[9:8] == 2'h0) ? 32'h00000100
           : 32'h00000000));
        drive_sides;
        rd(`CLK_STRAP_CONFIG_OFS, m_cs);
        rd(`UPSTREAM_BUF_THRESH_OFS, m_ub);
        rd(12'h050, 32'h00000000);
      end
      @(posedge sys_clk_in);
      rst_in <= 1'b1;
    end
    end_sim;
  end
endmodule // tb_top
